/* File: logic/hrpc_top.sv */
// Reset pad-state control and configuration-source selection for a hub.
// Assumes probe results for flash and EEPROM signatures come from boot
// logic elsewhere; this block sequences them and drives pad controls.
`timescale 1ns/10ps
module hrpc_top
    import hrpc_pkg::*;
#(
    parameter int TT_BUFS = TT_NP_BUFFERS
) (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic flash_probe_done_i,
    input wire logic flash_sig_ok_i,
    input wire logic ee_probe_done_i,
    input wire logic ee_sig1_ok_i,
    input wire logic ee_sig2_ok_i,
    input wire logic load_done_i,
    input wire logic host_cfg_write_i,
    output hrpc_pad_s downstream_pad_o [2*DOWN_PORTS],
    output hrpc_pad_s port_power_control_o [DOWN_PORTS],
    output hrpc_pad_s flash_select_o,
    output hrpc_pad_s serial_clock_o,
    output hrpc_pad_s serial_flash_out_shared_o,
    output hrpc_pad_s card_detect_o [CARD_DETECTS],
    output hrpc_pad_s card_bus_o [CARD_BUS_PADS],
    output hrpc_pad_s card_power_out_o,
    output logic card_detect_en_o,
    output hrpc_src_e cfg_source_o,
    output logic [15:0] fetch_addr_o,
    output logic [8:0] ee_check_addr_o,
    output logic cfg_write_en_o,
    output logic cfg_write_ack_o,
    output logic [1:0] tt_count_o,
    output logic [3:0] tt_buffers_o,
    output logic upstream_attach_o
);

    // ------------------------------------------------------------
    // Boot sequence state
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_FLASH = 5'h01,
        ST_EE1 = 5'h02,
        ST_EE2 = 5'h04,
        ST_LOAD = 5'h08,
        ST_READY = 5'h10
    } hrpc_state_e;

    hrpc_state_e state_reg, state_next;
    hrpc_src_e src_reg, src_next;
    logic attach_reg, attach_next;
    logic ack_reg, ack_next;
    logic wen_reg, wen_next;
    logic [15:0] faddr_reg, faddr_next;
    logic [8:0] eaddr_reg, eaddr_next;

    // Flash first, then EEPROM pair of signatures, else defaults
    always_comb begin
        state_next = state_reg;
        src_next = src_reg;
        attach_next = attach_reg;
        faddr_next = faddr_reg;
        eaddr_next = eaddr_reg;
        ack_next = 1'b0;
        case (state_reg)
            ST_FLASH: begin
                faddr_next = FLASH_SIG_ADDR;
                if (flash_probe_done_i) begin
                    if (flash_sig_ok_i) begin
                        src_next = SRC_FLASH;
                        faddr_next = FLASH_RUN_ADDR;
                        state_next = ST_LOAD;
                    end else begin
                        eaddr_next = EE_SIG1_ADDR;
                        state_next = ST_EE1;
                    end
                end
            end
            ST_EE1: begin
                if (ee_probe_done_i) begin
                    if (ee_sig1_ok_i) begin
                        eaddr_next = EE_SIG2_ADDR;
                        state_next = ST_EE2;
                    end else begin
                        src_next = SRC_DEFAULT;
                        state_next = ST_LOAD;
                    end
                end
            end
            ST_EE2: begin
                if (ee_probe_done_i) begin
                    // Both words must match, else fall back to defaults
                    if (ee_sig2_ok_i) begin
                        src_next = SRC_EEPROM;
                    end else begin
                        src_next = SRC_DEFAULT;
                    end
                    state_next = ST_LOAD;
                end
            end
            ST_LOAD: begin
                // Defaults need no fetch, so they count as loaded at once
                if (load_done_i || src_reg == SRC_DEFAULT) begin
                    attach_next = 1'b1;
                    state_next = ST_READY;
                end
            end
            ST_READY: begin
                ack_next = host_cfg_write_i && src_reg != SRC_DEFAULT;
            end
            default: begin
                state_next = ST_FLASH;
            end
        endcase
        // Registered so the write gate comes straight from a flip-flop
        wen_next = attach_next && src_next != SRC_DEFAULT;
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            state_reg <= ST_FLASH;
            src_reg <= SRC_DEFAULT;
            attach_reg <= 1'b0;
            ack_reg <= 1'b0;
            wen_reg <= 1'b0;
            faddr_reg <= FLASH_SIG_ADDR;
            eaddr_reg <= EE_SIG1_ADDR;
        end else if (ce_i) begin
            state_reg <= state_next;
            src_reg <= src_next;
            attach_reg <= attach_next;
            ack_reg <= ack_next;
            wen_reg <= wen_next;
            faddr_reg <= faddr_next;
            eaddr_reg <= eaddr_next;
        end
    end

    // ------------------------------------------------------------
    // Pad state registers
    // ------------------------------------------------------------
    // Functional pad settings are a simple idle choice; card and
    // flash protocol engines elsewhere would override them.
    logic func_reg, func_next;
    hrpc_pad_s dn_reg [2*DOWN_PORTS];
    hrpc_pad_s ppc_reg [DOWN_PORTS];
    hrpc_pad_s cd_reg [CARD_DETECTS];
    hrpc_pad_s cb_reg [CARD_BUS_PADS];
    hrpc_pad_s cs_reg, sck_reg, sdo_reg, cpwr_reg;
    hrpc_pad_s cs_next, sck_next, sdo_next, cpwr_next;
    logic cden_reg, cden_next;

    // Reset is synchronous, so reset pad states appear one edge later
    always_comb begin
        func_next = 1'b1;
        cs_next = func_reg ? PAD_DRV_1 : PAD_DRV_1;
        sck_next = func_reg ? PAD_DRV_0 : PAD_DRV_0;
        sdo_next = func_reg ? PAD_DRV_0 : PAD_DRV_0;
        cpwr_next = func_reg ? PAD_DRV_0 : PAD_HIZ;
        cden_next = func_reg;
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            func_reg <= 1'b0;
            cs_reg <= PAD_DRV_1;
            sck_reg <= PAD_DRV_0;
            sdo_reg <= PAD_DRV_0;
            cpwr_reg <= PAD_HIZ;
            cden_reg <= 1'b0;
        end else if (ce_i) begin
            func_reg <= func_next;
            cs_reg <= cs_next;
            sck_reg <= sck_next;
            sdo_reg <= sdo_next;
            cpwr_reg <= cpwr_next;
            cden_reg <= cden_next;
        end
    end

    // Per-pad groups
    for (genvar g = 0; g < 2*DOWN_PORTS; g++) begin : g_dn
        always_ff @(posedge clock_i) begin
            if (srst_i) begin
                dn_reg[g] <= PAD_IN_PD;
            end else if (ce_i) begin
                dn_reg[g] <= func_reg ? PAD_IN : PAD_IN_PD;
            end
        end
    end
    for (genvar g = 0; g < DOWN_PORTS; g++) begin : g_ppc
        always_ff @(posedge clock_i) begin
            if (srst_i) begin
                ppc_reg[g] <= PAD_DRV_0;
            end else if (ce_i) begin
                ppc_reg[g] <= PAD_DRV_0; // Power stays off until hub enables
            end
        end
    end
    for (genvar g = 0; g < CARD_DETECTS; g++) begin : g_cd
        always_ff @(posedge clock_i) begin
            if (srst_i) begin
                cd_reg[g] <= PAD_IN_PU;
            end else if (ce_i) begin
                cd_reg[g] <= PAD_IN_PU;
            end
        end
    end
    for (genvar g = 0; g < CARD_BUS_PADS; g++) begin : g_cb
        always_ff @(posedge clock_i) begin
            if (srst_i) begin
                cb_reg[g] <= PAD_HIZ;
            end else if (ce_i) begin
                cb_reg[g] <= func_reg ? PAD_IN : PAD_HIZ;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign downstream_pad_o = dn_reg;
    assign port_power_control_o = ppc_reg;
    assign flash_select_o = cs_reg;
    assign serial_clock_o = sck_reg;
    assign serial_flash_out_shared_o = sdo_reg;
    assign card_detect_o = cd_reg;
    assign card_bus_o = cb_reg;
    assign card_power_out_o = cpwr_reg;
    assign card_detect_en_o = cden_reg;
    assign cfg_source_o = src_reg;
    assign fetch_addr_o = faddr_reg;
    assign ee_check_addr_o = eaddr_reg;
    assign cfg_write_en_o = wen_reg;
    assign cfg_write_ack_o = ack_reg;
    assign tt_count_o = 2'(TT_COUNT);
    assign tt_buffers_o = 4'(TT_BUFS);
    assign upstream_attach_o = attach_reg;

endmodule // hrpc_top

/* File: logic/hrpc_pkg.sv */
// Constants, pad control types and configuration-source codes for the
// hub reset pad-state and configuration-select block.
// Assumes a single 50 MHz clock and a synchronous active-high reset.
//
// Overview of operation
// - In reset, downstream data pins are inputs with pull-down enabled.
// - In reset, both port power control outputs drive low, no pull.
// - In reset, serial flash chip select drives high.
// - In reset, three card-presence pins are inputs with pull-up, detect off.
// - In reset, card bus and card power pins are fully high impedance.
// - In reset, shared serial clock and data-out drive low, functions off.
// - One transaction translator is shared by both downstream ports.
// - The shared translator offers four non-periodic buffers.
// - Configuration comes from a 512-byte EEPROM or from serial flash.
// - With no external memory, built-in defaults are used.
// - With flash or EEPROM signatures valid, host may rewrite stored configuration.
// - Upstream attach is signalled only after configuration is loaded.
// - Serial flash signature at top address is checked first; run from zero.
// - Without flash, EEPROM is checked for two signature words.
package hrpc_pkg;

    // ------------------------------------------------------------
    // Pad control carrier
    // ------------------------------------------------------------
    typedef struct packed {
        logic oe;   // Output driver enabled
        logic out;  // Driven level
        logic ie;   // Input buffer enabled
        logic pu;   // Pull-up enabled
        logic pd;   // Pull-down enabled
    } hrpc_pad_s;

    localparam hrpc_pad_s PAD_IN_PD = 5'h05;   // ie, pd
    localparam hrpc_pad_s PAD_IN_PU = 5'h06;   // ie, pu
    localparam hrpc_pad_s PAD_DRV_0 = 5'h10;   // oe, low
    localparam hrpc_pad_s PAD_DRV_1 = 5'h18;   // oe, high
    localparam hrpc_pad_s PAD_HIZ = 5'h00;     // all off
    localparam hrpc_pad_s PAD_IN = 5'h04;      // plain input

    // ------------------------------------------------------------
    // Configuration sources and hub structure
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SRC_DEFAULT = 2'h0,
        SRC_EEPROM = 2'h1,
        SRC_FLASH = 2'h2
    } hrpc_src_e;

    localparam int TT_COUNT = 1;
    localparam int TT_NP_BUFFERS = 4;
    localparam int EEPROM_BYTES = 512;
    localparam logic [15:0] FLASH_SIG_ADDR = 16'hFFFA;
    localparam logic [15:0] FLASH_RUN_ADDR = 16'h0000;
    localparam logic [8:0] EE_SIG1_ADDR = 9'h0FC;
    localparam logic [8:0] EE_SIG2_ADDR = 9'h17C;
    localparam int DOWN_PORTS = 2;
    localparam int CARD_DETECTS = 3;
    localparam int CARD_BUS_PADS = 16;

endpackage

/* File: testbench/hrpc_properties.sv */
// Checker for the pad-state and config-select block, bound to its top.
// Assumes one clock, synchronous active-high reset and clock enable high.
`timescale 1ns/10ps
module hrpc_properties
    import hrpc_pkg::*;
#(
    parameter int TT_BUFS = TT_NP_BUFFERS
) (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic load_done_i,
    input wire logic host_cfg_write_i,
    input hrpc_pad_s downstream_pad_o [2*DOWN_PORTS],
    input hrpc_pad_s port_power_control_o [DOWN_PORTS],
    input hrpc_pad_s flash_select_o,
    input hrpc_pad_s serial_clock_o,
    input hrpc_pad_s serial_flash_out_shared_o,
    input hrpc_pad_s card_detect_o [CARD_DETECTS],
    input hrpc_pad_s card_bus_o [CARD_BUS_PADS],
    input hrpc_pad_s card_power_out_o,
    input wire logic card_detect_en_o,
    input hrpc_src_e cfg_source_o,
    input wire logic [15:0] fetch_addr_o,
    input wire logic [8:0] ee_check_addr_o,
    input wire logic cfg_write_en_o,
    input wire logic cfg_write_ack_o,
    input wire logic [1:0] tt_count_o,
    input wire logic [3:0] tt_buffers_o,
    input wire logic upstream_attach_o
);
    // ----------------------------------------
    // Reset pad groups folded into flags
    // ----------------------------------------
    logic [3:0] rst_ok;
    // Loops keep the wide card bus check short
    always_comb begin
        rst_ok[0] = port_power_control_o[0] == PAD_DRV_0
            && port_power_control_o[1] == PAD_DRV_0;
        for (int i = 0; i < 2 * DOWN_PORTS; i++)
            rst_ok[0] &= downstream_pad_o[i] == PAD_IN_PD;
        rst_ok[1] = flash_select_o == PAD_DRV_1
            && serial_clock_o == PAD_DRV_0
            && serial_flash_out_shared_o == PAD_DRV_0
            && fetch_addr_o == FLASH_SIG_ADDR;
        rst_ok[2] = card_power_out_o == PAD_HIZ && !card_detect_en_o;
        for (int i = 0; i < CARD_DETECTS; i++)
            rst_ok[2] &= card_detect_o[i] == PAD_IN_PU;
        for (int i = 0; i < CARD_BUS_PADS; i++)
            rst_ok[2] &= card_bus_o[i] == PAD_HIZ;
        rst_ok[3] = !upstream_attach_o && cfg_source_o == SRC_DEFAULT;
    end
    // Reset states must hold while reset is applied, so no disable here
    property p_rst(b);
        @(posedge clock_i) srst_i |=> b;
    endproperty
    a_rst_usb_pads: assert property (p_rst(rst_ok[0]))
        else $error("usb pads wrong in reset");
    a_rst_serial_pads: assert property (p_rst(rst_ok[1]))
        else $error("serial pads wrong in reset");
    a_rst_card_pads: assert property (p_rst(rst_ok[2]))
        else $error("card pads wrong in reset");
    a_rst_detached: assert property (p_rst(rst_ok[3]))
        else $error("attached in reset");
    a_tt_shape: assert property (
        @(posedge clock_i) disable iff (srst_i)
        tt_count_o == 2'(TT_COUNT) && tt_buffers_o == 4'(TT_BUFS))
        else $error("translator shape wrong");
    a_attach_cause: assert property (
        @(posedge clock_i) disable iff (srst_i)
        $rose(upstream_attach_o) |-> $past(load_done_i)
        || cfg_source_o == SRC_DEFAULT) else $error("attach before load");
    a_flash_run: assert property (
        @(posedge clock_i) disable iff (srst_i)
        cfg_source_o == SRC_FLASH |-> fetch_addr_o == FLASH_RUN_ADDR)
        else $error("flash fetch not at zero");
    a_ee_source: assert property (
        @(posedge clock_i) disable iff (srst_i)
        $changed(cfg_source_o) && cfg_source_o == SRC_EEPROM
        |-> $past(ee_check_addr_o) == EE_SIG2_ADDR)
        else $error("eeprom chosen early");
    a_write_ack: assert property (
        @(posedge clock_i) disable iff (srst_i)
        cfg_write_ack_o == ($past(host_cfg_write_i) && $past(upstream_attach_o)
        && $past(cfg_source_o) != SRC_DEFAULT)) else $error("write ack wrong");
    a_write_gate: assert property (
        @(posedge clock_i) disable iff (srst_i)
        cfg_write_en_o == (upstream_attach_o && cfg_source_o != SRC_DEFAULT))
        else $error("write enable wrong");
    a_pads_release: assert property (
        @(posedge clock_i) disable iff (srst_i)
        $fell(srst_i) |-> ##2 downstream_pad_o[0] == PAD_IN
        && card_power_out_o == PAD_DRV_0 && card_detect_en_o)
        else $error("pads not functional");
    c_flash: cover property (@(posedge clock_i) cfg_source_o == SRC_FLASH);
    c_eeprom: cover property (@(posedge clock_i) cfg_source_o == SRC_EEPROM);
    c_ack: cover property (@(posedge clock_i) cfg_write_ack_o);
endmodule // hrpc_properties

bind hrpc_top hrpc_properties #(.TT_BUFS(TT_BUFS)) u_props (
    .clock_i, .srst_i, .load_done_i, .host_cfg_write_i, .downstream_pad_o,
    .port_power_control_o, .flash_select_o, .serial_clock_o,
    .serial_flash_out_shared_o, .card_detect_o, .card_bus_o,
    .card_power_out_o, .card_detect_en_o, .cfg_source_o, .fetch_addr_o,
    .ee_check_addr_o, .cfg_write_en_o, .cfg_write_ack_o, .tt_count_o,
    .tt_buffers_o,
    .upstream_attach_o
);

/* File: testbench/hrpc_far_end.sv */
// Model of the configuration memories as seen through their probe results.
// Assumes mode 0 none, 1 eeprom, 2 flash, 3 eeprom with bad second word.
`timescale 1ns/10ps
module hrpc_far_end (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic [1:0] mode_i,
    input wire logic [3:0] delay_i,
    output logic done_o,
    output logic flash_ok_o,
    output logic ee_ok1_o,
    output logic ee_ok2_o,
    output logic loaded_o
);
    logic [3:0] cnt_reg;
    // Load time counts from release; a zero delay answers at once
    always_ff @(posedge clock_i) begin
        cnt_reg <= srst_i ? 4'h0 : cnt_reg + {3'h0, cnt_reg != 4'hF};
    end
    // Probe results are levels held from release onward
    assign done_o = !srst_i;
    assign flash_ok_o = mode_i == 2'h2;
    assign ee_ok1_o = mode_i[0];
    assign ee_ok2_o = mode_i == 2'h1;
    assign loaded_o = !srst_i && cnt_reg >= delay_i;
endmodule // hrpc_far_end

/* File: testbench/tb_top.sv */
// Self-checking bench: boots from each configuration source in turn.
// Assumes the far-end model answers probes; inputs change on falling edge.
`timescale 1ns/10ps
module tb_top;
    import hrpc_pkg::*;
    logic clock_i, srst_i = 1'b1, ce_i = 1'b1, host_cfg_write_i = 1'b0;
    logic flash_probe_done_i, flash_sig_ok_i, ee_probe_done_i;
    logic ee_sig1_ok_i, ee_sig2_ok_i, load_done_i;
    logic [1:0] mode = 2'h0;
    logic [3:0] delay = 4'h0;
    hrpc_pad_s downstream_pad_o [2*DOWN_PORTS];
    hrpc_pad_s port_power_control_o [DOWN_PORTS];
    hrpc_pad_s flash_select_o, serial_clock_o, serial_flash_out_shared_o;
    hrpc_pad_s card_detect_o [CARD_DETECTS];
    hrpc_pad_s card_bus_o [CARD_BUS_PADS];
    hrpc_pad_s card_power_out_o;
    hrpc_src_e cfg_source_o;
    logic [15:0] fetch_addr_o;
    logic [8:0] ee_check_addr_o;
    logic [1:0] tt_count_o;
    logic [3:0] tt_buffers_o;
    logic card_detect_en_o, cfg_write_en_o, cfg_write_ack_o, upstream_attach_o;
    int errors = 0;
    int total_checks = 0;
    assign ee_probe_done_i = flash_probe_done_i;
    hrpc_top u_dut (
        .clock_i, .srst_i, .ce_i, .flash_probe_done_i, .flash_sig_ok_i,
        .ee_probe_done_i, .ee_sig1_ok_i, .ee_sig2_ok_i, .load_done_i,
        .host_cfg_write_i, .downstream_pad_o, .port_power_control_o,
        .flash_select_o, .serial_clock_o, .serial_flash_out_shared_o,
        .card_detect_o, .card_bus_o, .card_power_out_o, .card_detect_en_o,
        .cfg_source_o, .fetch_addr_o, .ee_check_addr_o, .cfg_write_en_o,
        .cfg_write_ack_o, .tt_count_o, .tt_buffers_o, .upstream_attach_o
    );
    hrpc_far_end u_far (
        .clock_i, .srst_i, .mode_i(mode), .delay_i(delay),
        .done_o(flash_probe_done_i), .flash_ok_o(flash_sig_ok_i),
        .ee_ok1_o(ee_sig1_ok_i), .ee_ok2_o(ee_sig2_ok_i),
        .loaded_o(load_done_i)
    );
    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end
    // Compare with case equality so an unknown never matches
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        if (errors == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Reset with the far end set up, judge reset pads, wait for attach
    task automatic boot(input logic [1:0] m, input logic [3:0] d);
        int n;
        @(negedge clock_i);
        srst_i = 1'b1;
        mode = m;
        delay = d;
        repeat (8) @(negedge clock_i);
        check(downstream_pad_o[1], PAD_IN_PD);
        check(port_power_control_o[1], PAD_DRV_0);
        check(flash_select_o, PAD_DRV_1);
        check(card_detect_o[2], PAD_IN_PU);
        check(card_bus_o[9], PAD_HIZ);
        check(serial_clock_o, PAD_DRV_0);
        srst_i = 1'b0;
        n = 0;
        while (upstream_attach_o !== 1'b1 && n < 50) begin
            @(negedge clock_i);
            n++;
        end
        // A hang counts as a mismatch and ends the run at once
        if (upstream_attach_o !== 1'b1) begin
            errors++;
            summarize();
        end
        check(downstream_pad_o[3], PAD_IN);
        check(card_power_out_o, PAD_DRV_0);
        check(tt_count_o, 2'h1);
        check(tt_buffers_o, 4'h4);
    endtask
    // Hold a host rewrite for two cycles and judge each acknowledge
    task automatic host_write(input logic exp);
        host_cfg_write_i = 1'b1;
        repeat (2) begin
            @(negedge clock_i);
            check(cfg_write_ack_o, exp);
        end
        host_cfg_write_i = 1'b0;
    endtask
    // Valid flash signature: run from address zero once loaded
    task automatic flash_boot();
        boot(2'h2, 4'h3);
        check(cfg_source_o, SRC_FLASH);
        check(fetch_addr_o, FLASH_RUN_ADDR);
        check(load_done_i, 1'b1);
        check(cfg_write_en_o, 1'b1);
        host_write(1'b1);
    endtask
    // No flash, both EEPROM words valid: configure from the EEPROM
    task automatic eeprom_boot();
        boot(2'h1, 4'h0);
        check(cfg_source_o, SRC_EEPROM);
        check(ee_check_addr_o, EE_SIG2_ADDR);
        check(load_done_i, 1'b1);
        check(cfg_write_en_o, 1'b1);
        host_write(1'b1);
    endtask
    // Second EEPROM word bad: defaults, host rewrites refused
    task automatic bad_word_boot();
        boot(2'h3, 4'h2);
        check(cfg_source_o, SRC_DEFAULT);
        check(ee_check_addr_o, EE_SIG2_ADDR);
        check(cfg_write_en_o, 1'b0);
        host_write(1'b0);
    endtask
    // No memory at all: defaults, attach without any load
    task automatic no_memory_boot();
        boot(2'h0, 4'h0);
        check(cfg_source_o, SRC_DEFAULT);
        check(ee_check_addr_o, EE_SIG1_ADDR);
        check(cfg_write_en_o, 1'b0);
        host_write(1'b0);
    endtask
    initial begin
        flash_boot();
        eeprom_boot();
        bad_word_boot();
        no_memory_boot();
        summarize();
    end
endmodule // tb_top
